// File: pkg/usd_defines.svh
// register offsets, field positions and reset values of the serial port
`ifndef USD_DEFINES_SVH
`define USD_DEFINES_SVH
`define USD_OFF_DATA 32'h0000_0000
`define USD_OFF_CSRA 32'h0000_0004
`define USD_OFF_CSRB 32'h0000_0008
`define USD_OFF_CSRC 32'h0000_000C
`define USD_A_RX_DONE 7
`define USD_A_TX_DONE 6
`define USD_A_TX_EMPTY 5
`define USD_B_DONE_IE 6
`define USD_B_EMPTY_IE 5
`define USD_B_RX_ON 4
`define USD_B_TX_ON 3
`define USD_B_RX9 1
`define USD_B_TX9 0
`define USD_C_SYNC 6
`define USD_C_PEN 5
`define USD_C_PODD 4
`define USD_C_STOP2 3
`define USD_C_SIZE_HI 2
`define USD_C_SIZE_LO 0
`define USD_SIZE_NINE 3'h7
`define USD_RST_CSRC 8'h06
`define USD_FRAME_IDLE 13'h1FFF
`define USD_RESP_OKAY 2'h0
`define USD_RESP_SLVERR 2'h2
`endif

// File: pkg/usd_pkg.sv
// types shared by the serial port data path
`default_nettype none
package usd_pkg;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} usd_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DATA = 2'b01, RX_STOP = 2'b10} usd_rx_state_t;
    typedef struct packed {
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        logic [8:0] tx_buf;
        logic tx_empty;
        logic tx_done;
        logic tx_on;
        usd_tx_state_t tx_st;
        logic [12:0] tx_frame;
        logic [3:0] tx_cnt;
        logic tx_line;
        usd_rx_state_t rx_st;
        logic [3:0] rx_idx;
        logic [8:0] rx_shift;
        logic [8:0] rx_buf;
        logic rx_full;
        logic sclk_prev;
    } usd_state_t;
endpackage
`default_nettype wire

// File: rtl/usd_datapath.sv
// serial port transmit and receive data path with an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "usd_defines.svh"
`default_nettype none
module usd_datapath
(
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_awaddr, // write byte address
    input wire logic [2:0] s_axi_awprot, // protection, unused
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response code
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_araddr, // read byte address
    input wire logic [2:0] s_axi_arprot, // protection, unused
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response code
    input wire logic bit_tick, // one-cycle bit-rate strobe
    input wire logic serial_clock_pin, // external serial clock
    input wire logic serial_input_pin, // receive line
    output logic serial_output_pin, // transmit line level
    output logic serial_output_oe, // transmitter owns the output pin
    output logic serial_input_owned, // receiver owns the input pin
    output logic irq_tx_empty, // buffer-empty request, level
    output logic irq_tx_complete, // transmit-complete request, level
    input wire logic irq_tx_complete_ack // transmit-complete service pulse
);
    import usd_pkg::*;

    usd_state_t s_reg;
    usd_state_t s_next;

    // number of data bits selected by the character size code
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        if (code == `USD_SIZE_NINE)
            data_bits = 4'h9;
        else if (code[2])
            data_bits = 4'h8;
        else
            data_bits = 4'h5 + {2'h0, code[1:0]};
    endfunction

    // keeps only the bits that belong to the character
    function automatic logic [8:0] char_mask(input logic [3:0] n);
        char_mask = 9'h1FF >> (4'h9 - n);
    endfunction

    // builds the line image, start bit in bit 0, ones fill the stops
    function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                                input logic pen, input logic podd);
        logic [8:0] m;
        logic p;
        build_frame = `USD_FRAME_IDLE;
        m = d & char_mask(n);
        p = (^m) ^ podd;
        build_frame[0] = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            if (i < int'(n))
                build_frame[i + 1] = m[i];
        end
        for (int i = 1; i < 11; i++)
        begin
            if (pen && i == int'(n) + 1)
                build_frame[i] = p;
        end
    endfunction

    logic [3:0] nbits;
    logic sync_mode;
    logic tx_step;
    logic rx_sample;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_fire;
    logic rd_fire;
    logic [3:0] rd_idx;
    logic [7:0] stat_a;

    // frame format and bit timing sources
    always_comb
    begin
        nbits = data_bits(s_reg.ctrl_c[`USD_C_SIZE_HI:`USD_C_SIZE_LO]);
        sync_mode = s_reg.ctrl_c[`USD_C_SYNC];
        sclk_rise = serial_clock_pin & ~s_reg.sclk_prev;
        sclk_fall = ~serial_clock_pin & s_reg.sclk_prev;
        tx_step = sync_mode ? sclk_fall : bit_tick;
        rx_sample = sync_mode ? sclk_rise : bit_tick;
    end

    // bus handshakes and status image
    always_comb
    begin
        s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
        s_axi_wready = ~s_reg.w_got & ~s_reg.bvalid;
        s_axi_arready = ~s_reg.rvalid;
        s_axi_bvalid = s_reg.bvalid;
        s_axi_bresp = s_reg.bresp;
        s_axi_rvalid = s_reg.rvalid;
        s_axi_rresp = s_reg.rresp;
        s_axi_rdata = {24'h0, s_reg.rdata};
        wr_fire = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
        rd_fire = s_axi_arvalid & ~s_reg.rvalid;
        rd_idx = s_axi_araddr[5:2];
        stat_a = 8'h00;
        stat_a[`USD_A_RX_DONE] = s_reg.rx_full;
        stat_a[`USD_A_TX_DONE] = s_reg.tx_done;
        stat_a[`USD_A_TX_EMPTY] = s_reg.tx_empty;
    end

    // next state of the whole block
    always_comb
    begin
        logic [3:0] widx;
        logic tx_set_done;
        logic [7:0] rbyte;
        s_next = s_reg;
        widx = s_reg.aw_addr;
        tx_set_done = 1'b0;
        rbyte = 8'h00;
        s_next.sclk_prev = serial_clock_pin;

        // address and data captured in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr[5:2];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_next.w_got = 1'b1;
            s_next.w_data = s_axi_wdata[7:0];
            s_next.w_lane0 = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready)
            s_next.bvalid = 1'b0;
        if (s_reg.rvalid && s_axi_rready)
            s_next.rvalid = 1'b0;

        // transmit-complete service clears, a later set still wins
        if (irq_tx_complete_ack)
            s_next.tx_done = 1'b0;

        // register write with its side effects
        if (wr_fire)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `USD_RESP_OKAY;
            if (s_reg.w_lane0)
            begin
                unique case ({26'h0, widx, 2'b00})
                    `USD_OFF_DATA:
                    begin
                        if (s_reg.tx_empty)
                        begin
                            s_next.tx_buf = {s_reg.ctrl_b[`USD_B_TX9], s_reg.w_data};
                            s_next.tx_empty = 1'b0;
                        end
                    end
                    `USD_OFF_CSRA:
                    begin
                        if (s_reg.w_data[`USD_A_TX_DONE])
                            s_next.tx_done = 1'b0;
                    end
                    `USD_OFF_CSRB:
                        s_next.ctrl_b = s_reg.w_data & 8'h7D;
                    `USD_OFF_CSRC:
                        s_next.ctrl_c = s_reg.w_data & 8'h7F;
                    default:
                        s_next.bresp = `USD_RESP_SLVERR;
                endcase
            end
            else if (widx > 4'h3)
                s_next.bresp = `USD_RESP_SLVERR;
        end

        // register read; a data read empties the receive buffer
        if (rd_fire)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp = `USD_RESP_OKAY;
            unique case ({26'h0, rd_idx, 2'b00})
                `USD_OFF_DATA:
                begin
                    rbyte = s_reg.rx_buf[7:0];
                    s_next.rx_full = 1'b0;
                end
                `USD_OFF_CSRA:
                    rbyte = stat_a;
                `USD_OFF_CSRB:
                begin
                    rbyte = s_reg.ctrl_b;
                    rbyte[`USD_B_RX9] = s_reg.rx_buf[8];
                end
                `USD_OFF_CSRC:
                    rbyte = s_reg.ctrl_c;
                default:
                    s_next.rresp = `USD_RESP_SLVERR;
            endcase
            s_next.rdata = rbyte;
        end

        // transmitter shifting and reload
        unique case (s_reg.tx_st)
            TX_IDLE:
            begin
                if (s_reg.tx_on && !s_reg.tx_empty)
                begin
                    s_next.tx_frame = build_frame(s_reg.tx_buf, nbits,
                        s_reg.ctrl_c[`USD_C_PEN], s_reg.ctrl_c[`USD_C_PODD]);
                    s_next.tx_cnt = 4'h2 + nbits + {3'h0, s_reg.ctrl_c[`USD_C_PEN]}
                        + {3'h0, s_reg.ctrl_c[`USD_C_STOP2]};
                    s_next.tx_empty = 1'b1;
                    s_next.tx_st = TX_SHIFT;
                end
            end
            TX_SHIFT:
            begin
                if (tx_step)
                begin
                    s_next.tx_frame = {1'b1, s_reg.tx_frame[12:1]};
                    s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
                    if (s_reg.tx_cnt == 4'h1)
                    begin
                        s_next.tx_st = TX_IDLE;
                        if (!s_next.tx_empty && s_reg.tx_on)
                        begin
                            s_next.tx_frame = build_frame(s_next.tx_buf, nbits,
                                s_reg.ctrl_c[`USD_C_PEN], s_reg.ctrl_c[`USD_C_PODD]);
                            s_next.tx_cnt = 4'h2 + nbits + {3'h0, s_reg.ctrl_c[`USD_C_PEN]}
                                + {3'h0, s_reg.ctrl_c[`USD_C_STOP2]};
                            s_next.tx_empty = 1'b1;
                            s_next.tx_st = TX_SHIFT;
                        end
                        else
                            tx_set_done = 1'b1;
                    end
                end
            end
        endcase
        if (tx_set_done)
            s_next.tx_done = 1'b1;
        s_next.tx_line = s_next.tx_frame[0];

        // transmitter stays enabled until shifter and buffer are empty
        s_next.tx_on = s_next.ctrl_b[`USD_B_TX_ON] |
            (s_reg.tx_on & ((s_next.tx_st == TX_SHIFT) | ~s_next.tx_empty));
        if (!s_next.tx_on)
            s_next.tx_line = 1'b1;

        // receiver: start bit, data and parity, first stop only
        unique case (s_reg.rx_st)
            RX_IDLE:
            begin
                if (rx_sample && s_reg.ctrl_b[`USD_B_RX_ON] && !serial_input_pin)
                begin
                    s_next.rx_st = RX_DATA;
                    s_next.rx_idx = 4'h0;
                    s_next.rx_shift = 9'h000;
                end
            end
            RX_DATA:
            begin
                if (rx_sample)
                begin
                    if (s_reg.rx_idx < nbits)
                        s_next.rx_shift[s_reg.rx_idx] = serial_input_pin;
                    s_next.rx_idx = s_reg.rx_idx + 4'h1;
                    if (s_reg.rx_idx + 4'h1 == nbits + {3'h0, s_reg.ctrl_c[`USD_C_PEN]})
                        s_next.rx_st = RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (rx_sample)
                begin
                    s_next.rx_buf = s_reg.rx_shift & char_mask(nbits);
                    s_next.rx_full = 1'b1;
                    s_next.rx_st = RX_IDLE;
                end
            end
            default:
                s_next.rx_st = RX_IDLE;
        endcase
        if (!s_reg.ctrl_b[`USD_B_RX_ON])
            s_next.rx_st = RX_IDLE;
        if (s_reg.ctrl_b[`USD_B_RX_ON] == 1'b0 && s_next.ctrl_b[`USD_B_RX_ON] == 1'b0)
            s_next.rx_full = 1'b0;
    end

    // single register for all block state
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.ctrl_c <= `USD_RST_CSRC;
            s_reg.tx_empty <= 1'b1;
            s_reg.tx_line <= 1'b1;
            s_reg.tx_frame <= `USD_FRAME_IDLE;
            s_reg.tx_st <= TX_IDLE;
            s_reg.rx_st <= RX_IDLE;
        end
        else
            s_reg <= s_next;
    end

    // pin ownership and interrupt requests
    always_comb
    begin
        serial_output_pin = s_reg.tx_line;
        serial_output_oe = s_reg.tx_on;
        serial_input_owned = s_reg.ctrl_b[`USD_B_RX_ON];
        irq_tx_empty = s_reg.ctrl_b[`USD_B_EMPTY_IE] & s_reg.tx_empty;
        irq_tx_complete = s_reg.ctrl_b[`USD_B_DONE_IE] & s_reg.tx_done;
    end
endmodule
`default_nettype wire

// File: sim/usd_datapath_assertions.sv
// concurrent checks on the serial port data path ports
`timescale 1ns/100ps
`default_nettype none
module usd_chk
(
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic bit_tick, // bit strobe
    input wire logic serial_clock_pin, // serial clock
    input wire logic serial_output_pin, // transmit line
    input wire logic serial_output_oe, // transmit owner
    input wire logic irq_tx_complete, // complete request
    input wire logic irq_tx_complete_ack // service pulse
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // address and data taken together
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // service pulse while no bit step can finish a frame
    sequence ack_quiet;
        irq_tx_complete_ack && !bit_tick && $stable(serial_clock_pin);
    endsequence
    a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_line_released: assert property (!serial_output_oe |-> serial_output_pin)
        else $error("released line not idle");
    a_low_owned: assert property (!serial_output_pin |-> serial_output_oe)
        else $error("frame sent without owning pin");
    a_ack_clears: assert property (ack_quiet |=> !irq_tx_complete)
        else $error("complete request survives service");
    a_complete_idle: assert property ($rose(irq_tx_complete) |-> serial_output_pin)
        else $error("complete raised mid frame");
endmodule
bind usd_datapath usd_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .bit_tick(bit_tick), .serial_clock_pin(serial_clock_pin),
    .serial_output_pin(serial_output_pin), .serial_output_oe(serial_output_oe),
    .irq_tx_complete(irq_tx_complete), .irq_tx_complete_ack(irq_tx_complete_ack));
`default_nettype wire

// File: sim/usd_remote.sv
// remote serial port: sends frames and captures device frames
`timescale 1ns/100ps
`default_nettype none
module usd_remote
(
    input wire logic clk_sys, // clock
    input wire logic bit_tick, // bit strobe
    input wire logic tx_pin, // device line
    input wire logic tx_oe, // device drives line
    output logic rx_pin // line into device
);
    int nbits = 9;
    int cnt = -1;
    logic [11:0] sh;
    logic [11:0] got[$];
    wire logic rx_line = tx_oe ? tx_pin : 1'b1; // pull-up when released
    initial rx_pin = 1'b1;
    // capture bits after a low start, lsb first, up to the first stop
    always @(posedge clk_sys)
    begin
        if (bit_tick && cnt >= 0)
        begin
            sh[cnt] = rx_line;
            cnt++;
            if (cnt == nbits)
            begin
                got.push_back(sh);
                cnt = -1;
            end
        end
        else if (bit_tick && !rx_line)
        begin
            sh = '0;
            cnt = 0;
        end
    end
    // one frame: low start, n data bits lsb first, then high stop and idle
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = -1; i <= n; i++)
        begin
            @(posedge clk_sys iff bit_tick);
            rx_pin <= (i < 0) ? 1'b0 : ((i < n) ? bits[i] : 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// File: sim/usd_datapath_tb.sv
// self-checking bench for the serial port data path
`timescale 1ns/100ps
`include "usd_defines.svh"
`default_nettype none
module usd_datapath_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bit_tick = 1'b0;
    logic irq_tx_complete_ack = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wdata = '0, s_axi_rdata, q;
    logic [1:0] tcnt = '0, s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic serial_in, serial_output_pin, serial_output_oe, serial_input_owned;
    logic irq_tx_empty, irq_tx_complete;
    logic sclk = 1'b0, sync_run = 1'b0;
    logic [7:0] cfg[5] = '{8'h00, 8'h21, 8'h06, 8'h27, 8'h3A};
    logic [7:0] dat[5] = '{8'hFF, 8'hC5, 8'h96, 8'h3C, 8'h5A};
    int mismatches = 0, num_checks = 0, w;
    always #5 clk_sys = !clk_sys;
    // bit strobe every fourth cycle
    always @(posedge clk_sys)
    begin
        tcnt <= tcnt + 2'd1;
        bit_tick <= &tcnt;
        sclk <= sync_run & tcnt[1];
    end
    usd_datapath dut_u (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF),
        .serial_clock_pin(sclk), .serial_input_pin(serial_in));
    usd_remote remote_u (.clk_sys(clk_sys), .bit_tick(bit_tick), .tx_pin(serial_output_pin),
        .tx_oe(serial_output_oe), .rx_pin(serial_in));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus transfer; readies stay up until the answer is sampled
    task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
        output logic [31:0] qo, output logic [1:0] ro);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        qo = s_axi_rdata;
        ro = w ? s_axi_bresp : s_axi_rresp;
        if (!(w ? s_axi_bvalid : s_axi_rvalid))
        begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        acc(1'b1, a, d, q, r);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        acc(1'b0, a, 8'h00, q, r);
        chk(q, exp);
    endtask
    // poll a status bit with a bounded number of reads
    task automatic poll(input int b);
        int n;
        n = 0;
        q = '0;
        while (q[b] !== 1'b1 && n < 30)
        begin
            acc(1'b0, `USD_OFF_CSRA, 8'h00, q, r);
            n++;
        end
        if (q[b] !== 1'b1)
        begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic txwait(input logic [11:0] exp);
        int n;
        n = 0;
        while (remote_u.got.size() == 0 && n < 300)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (remote_u.got.size() == 0)
        begin
            mismatches++;
            wrap_up();
        end
        else
            chk(32'(remote_u.got.pop_front()), 32'(exp));
    endtask
    // expected bits after the start bit, up to the first stop
    function automatic logic [11:0] fr(input logic [8:0] d, input int w, input logic pen,
        input logic odd);
        logic [11:0] f;
        f = '0;
        for (int i = 0; i < w; i++)
            f[i] = d[i];
        f[w] = pen ? (^f ^ odd) : 1'b1;
        f[w + 32'(pen)] = 1'b1;
        return f;
    endfunction
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(`USD_OFF_CSRA, 32'h0000_0020);
        rdc(`USD_OFF_CSRB, 32'h0000_0000);
        rdc(`USD_OFF_CSRC, 32'h0000_0006);
        acc(1'b0, 32'h0000_0010, 8'h00, q, r);
        chk(32'(r), 32'h0000_0002);
        // every size code class, parity kinds, ninth bit and two stops
        foreach (cfg[i])
        begin
            w = cfg[i][2:0] == 3'h7 ? 9 : (cfg[i][2:0] > 3 ? 8 : 32'(cfg[i][2:0]) + 5);
            remote_u.nbits = w + 32'(cfg[i][5]) + 1;
            wr(`USD_OFF_CSRC, cfg[i]);
            wr(`USD_OFF_CSRB, {7'h04, w == 9});
            wr(`USD_OFF_DATA, dat[i]);
            txwait(fr({w == 9, dat[i]}, w, cfg[i][5], cfg[i][4]));
        end
        poll(6);
        wr(`USD_OFF_CSRC, 8'h06);
        remote_u.nbits = 9;
        wr(`USD_OFF_CSRA, 8'h40);
        wr(`USD_OFF_DATA, 8'h11);
        wr(`USD_OFF_DATA, 8'h22);
        rdc(`USD_OFF_CSRA, 32'h0000_0000);
        txwait(fr(9'h011, 8, 1'b0, 1'b0));
        txwait(fr(9'h022, 8, 1'b0, 1'b0));
        poll(6);
        rdc(`USD_OFF_CSRA, 32'h0000_0060);
        // requests, service pulse and a handler that turns the empty request off
        wr(`USD_OFF_CSRB, 8'h68);
        chk(32'(irq_tx_empty), 32'h1);
        chk(32'(irq_tx_complete), 32'h1);
        @(posedge clk_sys iff bit_tick);
        irq_tx_complete_ack <= 1'b1;
        @(posedge clk_sys);
        irq_tx_complete_ack <= 1'b0;
        @(posedge clk_sys);
        chk(32'(irq_tx_complete), 32'h0);
        wr(`USD_OFF_CSRB, 8'h48);
        chk(32'(irq_tx_empty), 32'h0);
        // disable while a frame is running
        wr(`USD_OFF_DATA, 8'h33);
        wr(`USD_OFF_CSRB, 8'h00);
        chk(32'(serial_output_oe), 32'h1);
        txwait(fr(9'h033, 8, 1'b0, 1'b0));
        repeat (8) @(posedge clk_sys);
        chk(32'(serial_output_oe), 32'h0);
        // seven-bit receive, two stops set, frames back to back
        wr(`USD_OFF_CSRC, 8'h0A);
        wr(`USD_OFF_CSRB, 8'h10);
        chk(32'(serial_input_owned), 32'h1);
        remote_u.send(12'h0D5, 7);
        fork
            remote_u.send(12'h02A, 7);
        join_none
        poll(7);
        rdc(`USD_OFF_DATA, 32'h0000_0055);
        poll(7);
        rdc(`USD_OFF_DATA, 32'h0000_002A);
        // synchronous receive: nothing is taken while the serial clock stands still
        wr(`USD_OFF_CSRC, 8'h46);
        remote_u.send(12'h0C3, 8);
        repeat (8) @(posedge clk_sys);
        rdc(`USD_OFF_CSRA, 32'h0000_0060);
        sync_run <= 1'b1;
        remote_u.send(12'h0A5, 8);
        poll(7);
        rdc(`USD_OFF_DATA, 32'h0000_00A5);
        wrap_up();
    end
endmodule
`default_nettype wire
